// file: inc/apd_pkg.sv
// Purpose: constants for the automatic power-down unit
// Assumes: power-mode register bits arrive as plain ports
// Notes:   one clock domain, pins synchronised inside the unit
package apd_pkg;
  localparam int          IDLE_W        = 4;
  localparam logic [3:0]  IDLE_LIMIT    = 4'hF;
  localparam int          BIT_SLEEP_EN  = 1;
  localparam int          BIT_FULLSPD_N = 3;
  localparam int          BIT_ARR_CLK   = 4;
  localparam int          BIT_MC_CLK    = 5;
  localparam logic [7:0]  PMR0_RESET    = 8'h00;
  localparam int          BLOCK_W       = 8;
  localparam logic [7:0]  BLOCK_RESET   = 8'h00;

  typedef enum logic [1:0] {APD_RUN, APD_DOWN} apd_state_t;
endpackage

// file: verilog/apd_unit.sv
// Purpose: auto power-down, chip-select gating and signal blocking
// Assumes: pin inputs are asynchronous; power-mode bits come from logic
// Notes:   strobe and clock input edges are detected on the core clock
`timescale 1ns/100ps

module apd_unit #(
  parameter int IDLE_W = apd_pkg::IDLE_W
) (
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        RST_N_I,
  input  wire logic                        ADDR_STROBE_I,
  input  wire logic                        PLD_CLOCK_INPUT_I,
  input  wire logic                        CHIP_SEL_N_I,
  input  wire logic                        PMR0_WR_I,
  input  wire logic [7:0]                  PMR0_WDATA_I,
  input  wire logic                        PMR2_WR_I,
  input  wire logic [apd_pkg::BLOCK_W-1:0] PMR2_WDATA_I,
  input  wire logic [apd_pkg::BLOCK_W-1:0] MCU_CTRL_I,
  input  wire logic [15:0]                 MCU_ADDR_I,
  input  wire logic [7:0]                  MCU_DATA_I,
  input  wire logic [7:0]                  PORT_OUT_I,
  output logic                             POWER_DOWN_FLAG_O,
  output logic [7:0]                       PMR0_RDATA_O,
  output logic [apd_pkg::BLOCK_W-1:0]      PMR2_RDATA_O,
  output logic [15:0]                      MEM_ADDR_O,
  output logic [7:0]                       MEM_DATA_O,
  output logic                             MEM_SEL_O,
  output logic                             IO_CONTROL_SPACE_SELECT_O,
  output logic [15:0]                      ARR_ADDR_O,
  output logic [apd_pkg::BLOCK_W-1:0]      ARR_CTRL_O,
  output logic                             ARR_CLK_EN_O,
  output logic                             MC_CLK_EN_O,
  output logic                             ARR_FULLSPEED_O,
  output logic [7:0]                       PORT_OUT_O,
  output logic                             DATA_PORT_OE_N_O
);
  // strobe, clock and chip select sync pipes
  logic [1:0] as_s_r, as_s_nxt, ck_s_r, ck_s_nxt, cs_s_r, cs_s_nxt;
  logic       as_d_r, as_d_nxt, ck_d_r, ck_d_nxt, cs_d_r, cs_d_nxt;
  logic       rst_seen_r, rst_seen_nxt;
  logic [7:0] pmr0_r, pmr0_nxt;
  logic [apd_pkg::BLOCK_W-1:0] pmr2_r, pmr2_nxt;
  logic [IDLE_W-1:0] idle_r, idle_nxt;
  apd_pkg::apd_state_t st_r, st_nxt;
  logic [15:0] addr_r, addr_nxt, arr_a_r, arr_a_nxt;
  logic [7:0]  data_r, data_nxt, pout_r, pout_nxt;
  logic [apd_pkg::BLOCK_W-1:0] actl_r, actl_nxt;
  logic as_edge, ck_edge, cs_fall, sleep_en, pd;

  function automatic logic rise(input logic now, input logic prev);
    rise = now & ~prev;
  endfunction

  // dedicated inputs, two flops before use
  always_comb
  begin
    as_s_nxt = {as_s_r[0], ADDR_STROBE_I};
    ck_s_nxt = {ck_s_r[0], PLD_CLOCK_INPUT_I};
    cs_s_nxt = {cs_s_r[0], CHIP_SEL_N_I};
    as_d_nxt = as_s_r[1];
    ck_d_nxt = ck_s_r[1];
    cs_d_nxt = cs_s_r[1];
    as_edge  = rise(as_s_r[1], as_d_r);
    ck_edge  = rise(ck_s_r[1], ck_d_r);
    // fall seen while the delayed copy is still high
    cs_fall  = rise(cs_d_r, cs_s_r[1]);
  end

  // pipes reset to idle pin levels: no false strobe edge
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      as_s_r <= '0;
      ck_s_r <= '0;
      cs_s_r <= '1;
      as_d_r <= 1'b0;
      ck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      as_s_r <= as_s_nxt;
      ck_s_r <= ck_s_nxt;
      cs_s_r <= cs_s_nxt;
      as_d_r <= as_d_nxt;
      ck_d_r <= ck_d_nxt;
      cs_d_r <= cs_d_nxt;
    end
  end

  // reset release counts as a wake event for one cycle
  always_comb
  begin
    rst_seen_nxt = 1'b1;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
      rst_seen_r <= 1'b0;
    else
      rst_seen_r <= rst_seen_nxt;
  end

  // power-mode registers, loaded whole by a write pulse
  always_comb
  begin
    pmr0_nxt = PMR0_WR_I ? PMR0_WDATA_I : pmr0_r;
    pmr2_nxt = PMR2_WR_I ? PMR2_WDATA_I : pmr2_r;
    // bit 1 enables the sleep unit
    sleep_en = pmr0_r[apd_pkg::BIT_SLEEP_EN];
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      pmr0_r <= apd_pkg::PMR0_RESET;
      pmr2_r <= apd_pkg::BLOCK_RESET;
    end
    else
    begin
      pmr0_r <= pmr0_nxt;
      pmr2_r <= pmr2_nxt;
    end
  end

  always_comb
  begin
    idle_nxt = idle_r;
    st_nxt   = st_r;
    case (st_r)
      apd_pkg::APD_RUN:
      begin
        if (as_edge || !sleep_en)
          idle_nxt = '0;
        // count idle clock periods; raw clock, ungated
        else if (ck_edge)
          idle_nxt = idle_r + 1'b1;
        if (sleep_en && !as_edge && idle_r == IDLE_W'(apd_pkg::IDLE_LIMIT))
          st_nxt = apd_pkg::APD_DOWN;
      end
      apd_pkg::APD_DOWN:
      begin
        // strobe, chip select fall, reset release wake
        if (as_edge || cs_fall || !rst_seen_r || !sleep_en)
        begin
          st_nxt   = apd_pkg::APD_RUN;
          idle_nxt = '0;
        end
      end
      default:
      begin
        st_nxt   = apd_pkg::APD_RUN;
        idle_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      idle_r <= '0;
      st_r   <= apd_pkg::APD_RUN;
    end
    else
    begin
      idle_r <= idle_nxt;
      st_r   <= st_nxt;
    end
  end

  assign pd = (st_r == apd_pkg::APD_DOWN);

  always_comb
  begin
    // freeze bus towards memories and arrays in power-down
    addr_nxt  = pd ? addr_r : MCU_ADDR_I;
    data_nxt  = pd ? data_r : MCU_DATA_I;
    arr_a_nxt = pd ? arr_a_r : MCU_ADDR_I;
    // blocking bits hold selected control lines low
    actl_nxt  = pd ? actl_r : (MCU_CTRL_I & ~pmr2_r);
    // port outputs keep level while down
    pout_nxt  = pd ? pout_r : PORT_OUT_I;
  end

  // frozen copies cost a cycle of latency on every bus path
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      addr_r  <= '0;
      data_r  <= '0;
      arr_a_r <= '0;
      actl_r  <= '0;
      pout_r  <= '0;
    end
    else
    begin
      addr_r  <= addr_nxt;
      data_r  <= data_nxt;
      arr_a_r <= arr_a_nxt;
      actl_r  <= actl_nxt;
      pout_r  <= pout_nxt;
    end
  end

  assign POWER_DOWN_FLAG_O = (st_r == apd_pkg::APD_DOWN);
  assign PMR0_RDATA_O      = pmr0_r;
  assign PMR2_RDATA_O      = pmr2_r;
  // memories see static inputs while frozen, so they idle
  assign MEM_ADDR_O        = addr_r;
  assign MEM_DATA_O        = data_r;
  // deselect on power-down or chip select high
  assign MEM_SEL_O                 = ~POWER_DOWN_FLAG_O & ~cs_d_r;
  assign IO_CONTROL_SPACE_SELECT_O = ~POWER_DOWN_FLAG_O & ~cs_d_r;
  assign ARR_ADDR_O        = arr_a_r;
  assign ARR_CTRL_O        = actl_r;
  // clock gates to array and macrocells
  assign ARR_CLK_EN_O      = ~pmr0_r[apd_pkg::BIT_ARR_CLK];
  assign MC_CLK_EN_O       = ~pmr0_r[apd_pkg::BIT_MC_CLK];
  // arrays depend only on full-speed bit
  assign ARR_FULLSPEED_O   = ~pmr0_r[apd_pkg::BIT_FULLSPD_N];
  assign PORT_OUT_O        = pout_r;
  // data port floats in power-down (enable low drives)
  assign DATA_PORT_OE_N_O  = POWER_DOWN_FLAG_O;
endmodule

// file: dv/apd_unit_monitor.sv
// Purpose: port checks of apd_unit
// Assumes: flag is the state
// Notes:   wake windows cover syncs
`timescale 1ns/100ps
module apd_unit_monitor (
  input wire logic        CORE_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        ADDR_STROBE_I,
  input wire logic        CHIP_SEL_N_I,
  input wire logic        POWER_DOWN_FLAG_O,
  input wire logic [7:0]  PMR0_RDATA_O,
  input wire logic [15:0] MEM_ADDR_O,
  input wire logic        MEM_SEL_O,
  input wire logic        ARR_CLK_EN_O,
  input wire logic        MC_CLK_EN_O,
  input wire logic        ARR_FULLSPEED_O,
  input wire logic        DATA_PORT_OE_N_O
);
  default clocking @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  sequence woke_s;
    ##[1:8] !POWER_DOWN_FLAG_O;
  endsequence
  entry_armed_a: assert property ($rose(POWER_DOWN_FLAG_O) |-> $past(PMR0_RDATA_O[1]))
    else $error("entry while off");
  strobe_wake_a: assert property ($rose(ADDR_STROBE_I) && POWER_DOWN_FLAG_O |-> woke_s)
    else $error("no strobe wake");
  cs_wake_a: assert property ($fell(CHIP_SEL_N_I) && POWER_DOWN_FLAG_O |-> woke_s)
    else $error("no select wake");
  mem_desel_a: assert property (POWER_DOWN_FLAG_O |-> !MEM_SEL_O)
    else $error("memory selected");
  bus_frozen_a: assert property (POWER_DOWN_FLAG_O [*2] |-> $stable(MEM_ADDR_O))
    else $error("address leaked");
  port_float_a: assert property (POWER_DOWN_FLAG_O |-> DATA_PORT_OE_N_O)
    else $error("data port driven");
  fullspd_bit_a: assert property (ARR_FULLSPEED_O == !PMR0_RDATA_O[3])
    else $error("full speed wrong");
  clk_gate_a: assert property (
    ARR_CLK_EN_O != PMR0_RDATA_O[4] && MC_CLK_EN_O != PMR0_RDATA_O[5])
    else $error("clock gate wrong");
  desel_cs_a: assert property (CHIP_SEL_N_I |-> ##3 !MEM_SEL_O)
    else $error("selected while high");
endmodule
bind apd_unit apd_unit_monitor apd_unit_monitor_i (.*);

// file: dv/apd_bus_model.sv
// Purpose: bus side of the unit
// Assumes: strobe only while active
// Notes:   clock input never stops
`timescale 1ns/100ps
module apd_bus_model (
  input  wire logic clk_i,
  input  wire logic active_i,
  output logic      strobe_o,
  output logic      pld_clk_o
);
  logic [2:0] tick_r   = 3'h0;
  logic       strobe_r = 1'b0;
  logic       clk_r    = 1'b0;
  always @(negedge clk_i)
  begin
    tick_r   <= tick_r + 3'h1;
    clk_r    <= tick_r[1];
    strobe_r <= active_i & (tick_r == 3'h7);
  end
  assign strobe_o  = strobe_r;
  assign pld_clk_o = clk_r;
endmodule

// file: dv/apd_unit_tb.sv
// Purpose: directed test of apd_unit
// Assumes: bus model makes strobe
// Notes:   inputs move on falling edge
`timescale 1ns/100ps
module apd_unit_tb;
  logic        clk = 1'b0, rst_n = 1'b0, act = 1'b1, cs_n = 1'b0, w0 = 1'b0, w2 = 1'b0;
  logic        st, pc, pd, ms, fs, ce, me, oe, io;
  logic [7:0]  d = 8'h00, r0, ac, md, p2, pt, pi = 8'h5a;
  logic [15:0] a = 16'h1234, ma, aa;
  int          errors = 0, samples_checked = 0, n;
  always #25 clk = ~clk;
  apd_bus_model apd_bus_model_i (.clk_i(clk), .active_i(act), .strobe_o(st), .pld_clk_o(pc));
  apd_unit apd_unit_i (.CORE_CLK_I(clk), .RST_N_I(rst_n), .ADDR_STROBE_I(st),
    .PLD_CLOCK_INPUT_I(pc), .CHIP_SEL_N_I(cs_n), .PMR0_WR_I(w0), .PMR0_WDATA_I(d),
    .PMR2_WR_I(w2), .PMR2_WDATA_I(d), .MCU_CTRL_I(8'hff), .MCU_ADDR_I(a), .MCU_DATA_I(d),
    .PORT_OUT_I(pi), .POWER_DOWN_FLAG_O(pd), .PMR0_RDATA_O(r0), .PMR2_RDATA_O(p2),
    .MEM_ADDR_O(ma), .MEM_DATA_O(md), .MEM_SEL_O(ms), .IO_CONTROL_SPACE_SELECT_O(io),
    .ARR_ADDR_O(aa), .ARR_CTRL_O(ac), .ARR_CLK_EN_O(ce), .MC_CLK_EN_O(me),
    .ARR_FULLSPEED_O(fs), .PORT_OUT_O(pt), .DATA_PORT_OE_N_O(oe));
  task automatic chk(input string s, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic sel2, input logic [7:0] v);
    d = v;
    w0 = !sel2;
    w2 = sel2;
    @(negedge clk);
    {w0, w2} = 2'b00;
    @(negedge clk);
  endtask
  task automatic wpd(input logic lv, input int lim);
    n = 0;
    while (pd !== lv && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #150000;
    errors++;
    complete_run;
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("reset", 16'h0100, 16'({fs, r0}));
    chk("rst outs", 16'h001e, 16'({pd, ms, io, ce, me, oe}));
    wr(1'b0, 8'h02);
    repeat (150) @(negedge clk);
    chk("busy", 16'h0000, 16'(pd));
    act <= 1'b0;
    wpd(1'b1, 300);
    chk("entry", 16'h0001, 16'(n > 45 && n < 100));
    a = 16'hbeef;
    d = 8'ha5;
    pi = 8'hc3;
    repeat (3) @(negedge clk);
    chk("addr", 16'h1234, ma);
    chk("arr addr", 16'h1234, aa);
    chk("data", 16'h0002, 16'(md));
    chk("io sel", 16'h0000, 16'(io));
    chk("port", 16'h005a, 16'(pt));
    chk("pins", 16'h0001, 16'({ms, oe}));
    act <= 1'b1;
    wpd(1'b0, 40);
    chk("strobe", 16'h0000, 16'(pd));
    @(negedge clk);
    chk("addr on", 16'hbeef, ma);
    chk("arr on", 16'hbeef, aa);
    chk("data on", 16'ha5c3, {md, pt});
    cs_n = 1'b1;
    act <= 1'b0;
    repeat (5) @(negedge clk);
    chk("desel", 16'h0000, 16'({ms, io}));
    wpd(1'b1, 300);
    chk("re-entry", 16'h0001, 16'(pd));
    cs_n = 1'b0;
    wpd(1'b0, 10);
    chk("select", 16'h0000, 16'(pd));
    wr(1'b0, 8'h38);
    repeat (150) @(negedge clk);
    chk("off", 16'h0000, 16'(pd));
    chk("modes", 16'h0038, 16'({fs, ce, me, r0}));
    wr(1'b1, 8'h0f);
    repeat (2) @(negedge clk);
    chk("ctrl", 16'h0ff0, {p2, ac});
    wr(1'b0, 8'h02);
    wpd(1'b1, 300);
    chk("down again", 16'h0001, 16'(pd));
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("reset wake", 16'h0100, 16'({pd, fs, r0}));
    complete_run;
  end
endmodule
